//--- ulpi_serial_pkg.sv
// Constants and types shared by both ends of the serial-mode ULPI link
// Operation
// - Link sets six-wire select bit to enter
// - Stop signal ends six-wire mode, back to sync
// - Link sets three-wire select bit to enter
// - Stop signal ends three-wire mode, back to sync
// - Clock runs in serial only with keep-clock bit
// - Six-wire: link drives enable, value, single zero
// - Six-wire: device drives plus, minus, differential, low
// - Serial modes: bit 3 is unmasked interrupt
// - Three-wire bit 1 shared by transmit enable
// - Three-wire bit 2 shared by transmit enable
// - Three-wire: upper four bits driven low
// - Resistors from fields; mode 01b forces off
// - Pull-up off for host, power-up, three-state
// - Pull-downs on for power-up and host settings
// - Termination on for select 00b, termination 0
// - Host suspend and resume: pull-downs only
// - Link alone programs the signaling state fields
// - Direction held high throughout serial modes
// - Link holds stop high until sync returns
package ulpi_serial_pkg;
   // Device register addresses on the ULPI bus
   localparam logic [5:0] REG_FUNC = 6'h04;
   localparam logic [5:0] REG_IFC = 6'h07;
   localparam logic [5:0] REG_OTG = 6'h0a;
   localparam logic [5:0] REG_IMASK = 6'h0d;
   // Field positions
   localparam int F_SPEED = 0;
   localparam int F_TERM = 2;
   localparam int F_OPMODE = 3;
   localparam int F_SIX = 0;
   localparam int F_THREE = 1;
   localparam int F_KEEPCLK = 3;
   localparam int F_PLUS_PD = 1;
   localparam int F_MINUS_PD = 2;
   // Reset values
   localparam logic [7:0] FUNC_RST = 8'h41;
   localparam logic [7:0] IFC_RST = 8'h00;
   localparam logic [7:0] OTG_RST = 8'h06;
   localparam logic [7:0] IMASK_RST = 8'h0f;
   // Field codes
   localparam logic [1:0] SPEED_HIGH = 2'b00;
   localparam logic [1:0] OPMODE_NODRIVE = 2'b01;
   localparam logic [1:0] CMD_REGWRITE = 2'b10;
   localparam int INT_SRC_W = 4;
   // Bus bit positions in serial modes
   localparam int B_TXEN = 0;
   localparam int B_TXVAL = 1;
   localparam int B_TXZERO = 2;
   localparam int B_INT = 3;
   localparam int B_RPLUS = 4;
   localparam int B_RMINUS = 5;
   localparam int B_RDIFF = 6;
   localparam logic [7:0] OE_SIX = 8'hf8;
   localparam logic [7:0] OE_THREE_RX = 8'hfe;
   // Link register map on AHB-Lite
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_SERTX = 8'h04;
   localparam logic [7:0] A_EXIT = 8'h08;
   localparam logic [7:0] A_STATUS = 8'h0c;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   typedef enum logic [2:0] {
      PM_SYNC = 3'b001,
      PM_SIX = 3'b010,
      PM_THREE = 3'b100
   } phy_mode_t;

   typedef enum logic [3:0] {
      W_IDLE = 4'b0001,
      W_ACK = 4'b0010,
      W_DATA = 4'b0100,
      W_STP = 4'b1000
   } wr_state_t;

   typedef enum logic [5:0] {
      L_IDLE = 6'b000001,
      L_CMD = 6'b000010,
      L_DATA = 6'b000100,
      L_STOP = 6'b001000,
      L_SERIAL = 6'b010000,
      L_WAKE = 6'b100000
   } link_state_t;
endpackage

//--- ulpi_if.sv
// ULPI bus between link and transceiver, with the shared data lines resolved
`timescale 1ns/10ps
interface ulpi_if;
   logic dir;
   logic nxt;
   logic stp;
   logic [7:0] phy_data_o;
   logic [7:0] phy_data_oe;
   logic [7:0] link_data_o;
   logic [7:0] link_data_oe;
   logic [7:0] data;

   // Undriven lines read low, as with the bus keeper
   assign data = (phy_data_o & phy_data_oe) | (link_data_o & link_data_oe);

   modport phy (
      output dir,
      output nxt,
      output phy_data_o,
      output phy_data_oe,
      input stp,
      input data
   );

   modport link (
      output stp,
      output link_data_o,
      output link_data_oe,
      input dir,
      input nxt,
      input data
   );
endinterface

//--- ulpi_serial_phy.sv
// Transceiver end: register writes, serial-mode bus remapping, resistor enables
`timescale 1ns/10ps
module ulpi_serial_phy import ulpi_serial_pkg::*; (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // ULPI bus
   ulpi_if.phy ulpi,
   // Line receivers and interrupt sources
   input wire logic line_plus,
   input wire logic line_minus,
   input wire logic [INT_SRC_W-1:0] int_source,
   // Line transmitter controls
   output logic serial_tx_enable,
   output logic serial_tx_diff_value,
   output logic serial_tx_single_ended_zero,
   // Resistor enables and clock gate
   output logic plus_pullup_on,
   output logic plus_pulldown_on,
   output logic minus_pulldown_on,
   output logic fast_termination_on,
   output logic clock_running
);

   phy_mode_t mode_q;
   wr_state_t wr_q;
   logic [5:0] addr_q;
   logic [7:0] func_q;
   logic [7:0] interface_control_reg;
   logic [7:0] otg_q;
   logic [7:0] imask_q;
   logic dir_q;
   logic nxt_q;
   logic [7:0] dout_q;
   logic [7:0] doe_q;
   logic [1:0] line_s1_q;
   logic [1:0] line_s2_q;
   logic [INT_SRC_W-1:0] int_s1_q;
   logic [INT_SRC_W-1:0] int_s2_q;
   logic tx_en_q;
   logic tx_val_q;
   logic tx_zero_q;
   logic pu_q;
   logic pdp_q;
   logic pdm_q;
   logic term_q;
   logic clk_run_q;

   logic serial;
   logic wr_commit;
   logic leave_serial;
   logic int_level;
   logic rcv_plus_line;
   logic rcv_minus_line;
   logic rcv_differential_value;
   logic bidir_single_zero;
   logic [1:0] transceiver_speed_select;
   logic termination_select;
   logic [1:0] operating_mode_select;
   logic plus_line_pull_low;
   logic minus_line_pull_low;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for cable-side and interrupt inputs

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_s1_q <= 2'h0;
         line_s2_q <= 2'h0;
         int_s1_q <= '0;
         int_s2_q <= '0;
      end else if (clk_en) begin
         line_s1_q <= {line_minus, line_plus};
         line_s2_q <= line_s1_q;
         int_s1_q <= int_source;
         int_s2_q <= int_s1_q;
      end
   end

   assign rcv_plus_line = line_s2_q[0];
   assign rcv_minus_line = line_s2_q[1];
   // Plus line stands in for the analog differential receiver
   assign rcv_differential_value = line_s2_q[0];
   assign bidir_single_zero = ~line_s2_q[0] & ~line_s2_q[1];
   assign int_level = |(int_s2_q & imask_q[INT_SRC_W-1:0]);

   ////////////////////////////////////////////////////////////////////////////
   // Register write sequence: command, data, stop

   assign serial = (mode_q != PM_SYNC);
   assign wr_commit = (wr_q == W_DATA);
   assign leave_serial = serial && ulpi.stp;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= W_IDLE;
         addr_q <= 6'h00;
         nxt_q <= 1'b0;
      end else if (clk_en) begin
         case (wr_q)
            W_IDLE: begin
               // Stop still high right after leaving serial mode is ignored
               if (!serial && ulpi.data[7:6] == CMD_REGWRITE) begin
                  addr_q <= ulpi.data[5:0];
                  nxt_q <= 1'b1;
                  wr_q <= W_ACK;
               end
            end
            W_ACK: begin
               nxt_q <= 1'b0;
               wr_q <= W_DATA;
            end
            W_DATA: begin
               nxt_q <= 1'b1;
               wr_q <= W_STP;
            end
            W_STP: begin
               nxt_q <= 1'b0;
               if (ulpi.stp) begin
                  wr_q <= W_IDLE;
               end
            end
            default: begin
               nxt_q <= 1'b0;
               wr_q <= W_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         func_q <= FUNC_RST;
         otg_q <= OTG_RST;
         imask_q <= IMASK_RST;
      end else if (clk_en && wr_commit) begin
         case (addr_q)
            REG_FUNC: func_q <= ulpi.data;
            REG_OTG: otg_q <= ulpi.data;
            REG_IMASK: imask_q <= ulpi.data;
            default: begin
            end
         endcase
      end
   end

   // Serial select bits self-clear when the link wakes the bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interface_control_reg <= IFC_RST;
      end else if (clk_en) begin
         if (wr_commit && addr_q == REG_IFC) begin
            interface_control_reg <= ulpi.data;
         end else if (leave_serial) begin
            interface_control_reg[F_SIX] <= 1'b0;
            interface_control_reg[F_THREE] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode and direction

   // Mode switches only once the write is closed by stop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= PM_SYNC;
         dir_q <= 1'b0;
      end else if (clk_en) begin
         case (mode_q)
            PM_SYNC: begin
               if (wr_q == W_STP && ulpi.stp) begin
                  if (interface_control_reg[F_SIX]) begin
                     mode_q <= PM_SIX;
                     dir_q <= 1'b1;
                  end else if (interface_control_reg[F_THREE]) begin
                     mode_q <= PM_THREE;
                     dir_q <= 1'b1;
                  end
               end
            end
            PM_SIX, PM_THREE: begin
               if (leave_serial) begin
                  mode_q <= PM_SYNC;
                  dir_q <= 1'b0;
               end
            end
            default: begin
               mode_q <= PM_SYNC;
               dir_q <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data bus drive in serial modes

   // Shared lines follow transmit enable one cycle late; link leaves a gap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout_q <= 8'h00;
         doe_q <= 8'h00;
      end else if (clk_en) begin
         dout_q <= 8'h00;
         doe_q <= 8'h00;
         if (mode_q == PM_SIX && !leave_serial) begin
            dout_q[B_INT] <= int_level;
            dout_q[B_RPLUS] <= rcv_plus_line;
            dout_q[B_RMINUS] <= rcv_minus_line;
            dout_q[B_RDIFF] <= rcv_differential_value;
            doe_q <= OE_SIX;
         end else if (mode_q == PM_THREE && !leave_serial) begin
            dout_q[B_INT] <= int_level;
            dout_q[B_TXVAL] <= rcv_differential_value;
            dout_q[B_TXZERO] <= bidir_single_zero;
            doe_q <= ulpi.data[B_TXEN] ? OE_SIX : OE_THREE_RX;
            // Upper bits stay low through the per-cycle dout_q default of zero
         end
      end
   end

   // Transmit controls from the link's pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_en_q <= 1'b0;
         tx_val_q <= 1'b0;
         tx_zero_q <= 1'b0;
      end else if (clk_en) begin
         tx_en_q <= serial && ulpi.data[B_TXEN];
         tx_val_q <= serial && ulpi.data[B_TXEN] && ulpi.data[B_TXVAL];
         tx_zero_q <= serial && ulpi.data[B_TXEN] && ulpi.data[B_TXZERO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Resistor decode

   assign transceiver_speed_select = func_q[F_SPEED +: 2];
   assign termination_select = func_q[F_TERM];
   assign operating_mode_select = func_q[F_OPMODE +: 2];
   assign plus_line_pull_low = otg_q[F_PLUS_PD];
   assign minus_line_pull_low = otg_q[F_MINUS_PD];

   // Host rows carry the plus pull-down, which also vetoes the pull-up
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pu_q <= 1'b0;
         pdp_q <= 1'b0;
         pdm_q <= 1'b0;
         term_q <= 1'b0;
      end else if (clk_en) begin
         if (operating_mode_select == OPMODE_NODRIVE) begin
            pu_q <= 1'b0;
            pdp_q <= 1'b0;
            pdm_q <= 1'b0;
            term_q <= 1'b0;
         end else begin
            pu_q <= termination_select && !plus_line_pull_low;
            pdp_q <= plus_line_pull_low;
            pdm_q <= minus_line_pull_low;
            term_q <= transceiver_speed_select == SPEED_HIGH
                      && !termination_select;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output clock gate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_run_q <= 1'b1;
      end else if (clk_en) begin
         clk_run_q <= !serial || interface_control_reg[F_KEEPCLK];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign ulpi.dir = dir_q;
   assign ulpi.nxt = nxt_q;
   assign ulpi.phy_data_o = dout_q;
   assign ulpi.phy_data_oe = doe_q;
   assign serial_tx_enable = tx_en_q;
   assign serial_tx_diff_value = tx_val_q;
   assign serial_tx_single_ended_zero = tx_zero_q;
   assign plus_pullup_on = pu_q;
   assign plus_pulldown_on = pdp_q;
   assign minus_pulldown_on = pdm_q;
   assign fast_termination_on = term_q;
   assign clock_running = clk_run_q;
endmodule

//--- ulpi_serial_link.sv
// Link end: AHB-Lite registers, register writes over ULPI, serial-mode drive
`timescale 1ns/10ps
module ulpi_serial_link import ulpi_serial_pkg::*; (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // ULPI bus
   ulpi_if.link ulpi
);

   link_state_t st_q;
   logic [7:0] a_addr_q;
   logic a_wr_q;
   logic [31:0] rdata_q;
   logic rdy_q;
   logic [5:0] cmd_addr_q;
   logic [7:0] cmd_data_q;
   logic [2:0] sertx_q;
   logic tx_en_prev_q;
   logic three_q;
   logic exit_q;
   logic stp_q;
   logic [7:0] dout_q;
   logic [7:0] doe_q;

   logic addr_ok;
   logic w_cmd;
   logic go;
   logic busy;
   logic [31:0] status;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY

   assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hsize == 3'b010;
   assign w_cmd = a_wr_q && a_addr_q == A_CMD;
   assign busy = st_q != L_IDLE && st_q != L_SERIAL;
   assign go = w_cmd && st_q == L_IDLE && !ulpi.dir;
   assign status = {16'h0000, ulpi.data, 3'b000, three_q, ulpi.dir,
                    st_q == L_SERIAL, exit_q, busy};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_addr_q <= 8'h00;
         a_wr_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rdy_q <= 1'b0;
      end else if (clk_en) begin
         rdy_q <= 1'b1;
         a_wr_q <= addr_ok && hwrite;
         if (addr_ok) begin
            a_addr_q <= haddr;
         end
         if (addr_ok && !hwrite) begin
            case (haddr)
               A_CMD: rdata_q <= {18'h0, cmd_addr_q, cmd_data_q};
               A_SERTX: rdata_q <= {29'h0, sertx_q};
               A_STATUS: rdata_q <= status;
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_addr_q <= 6'h00;
         cmd_data_q <= 8'h00;
         sertx_q <= 3'h0;
      end else if (clk_en && a_wr_q) begin
         if (go) begin
            cmd_addr_q <= hwdata[13:8];
            cmd_data_q <= hwdata[7:0];
         end
         if (a_addr_q == A_SERTX) begin
            sertx_q <= hwdata[2:0];
         end
      end
   end

   // Wake request stays pending until the bus is back
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exit_q <= 1'b0;
      end else if (clk_en) begin
         if (a_wr_q && a_addr_q == A_EXIT && hwdata[0]) begin
            exit_q <= 1'b1;
         end else if (st_q == L_WAKE && !ulpi.dir) begin
            exit_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ULPI sequencing

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= L_IDLE;
         stp_q <= 1'b0;
         three_q <= 1'b0;
      end else if (clk_en) begin
         case (st_q)
            L_IDLE: begin
               stp_q <= 1'b0;
               if (ulpi.dir) begin
                  st_q <= L_SERIAL;
               end else if (go) begin
                  st_q <= L_CMD;
                  if (hwdata[13:8] == REG_IFC) begin
                     three_q <= hwdata[F_THREE] && !hwdata[F_SIX];
                  end
               end
            end
            L_CMD: if (ulpi.nxt) st_q <= L_DATA;
            L_DATA: begin
               if (ulpi.nxt) begin
                  stp_q <= 1'b1;
                  st_q <= L_STOP;
               end
            end
            L_STOP: begin
               stp_q <= 1'b0;
               st_q <= L_IDLE;
            end
            L_SERIAL: begin
               if (exit_q) begin
                  stp_q <= 1'b1;
                  st_q <= L_WAKE;
               end
            end
            L_WAKE: begin
               if (!ulpi.dir) begin
                  stp_q <= 1'b0;
                  st_q <= L_IDLE;
               end
            end
            default: begin
               stp_q <= 1'b0;
               st_q <= L_IDLE;
            end
         endcase
      end
   end

   // Three-wire: shared lines driven only after enable was high a cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout_q <= 8'h00;
         doe_q <= 8'h00;
         tx_en_prev_q <= 1'b0;
      end else if (clk_en) begin
         dout_q <= 8'h00;
         doe_q <= 8'h00;
         tx_en_prev_q <= 1'b0;
         if (go) begin
            dout_q <= {CMD_REGWRITE, hwdata[13:8]};
            doe_q <= 8'hff;
         end else if (st_q == L_CMD && !ulpi.nxt) begin
            dout_q <= {CMD_REGWRITE, cmd_addr_q};
            doe_q <= 8'hff;
         end else if (st_q == L_CMD || (st_q == L_DATA && !ulpi.nxt)) begin
            dout_q <= cmd_data_q;
            doe_q <= 8'hff;
         end else if (st_q == L_SERIAL && !exit_q) begin
            tx_en_prev_q <= sertx_q[B_TXEN];
            dout_q[2:0] <= sertx_q;
            doe_q[B_TXEN] <= 1'b1;
            if (!three_q || (sertx_q[B_TXEN] && tx_en_prev_q)) begin
               doe_q[B_TXZERO:B_TXVAL] <= 2'b11;
            end
         end
      end
   end

   assign ulpi.stp = stp_q;
   assign ulpi.link_data_o = dout_q;
   assign ulpi.link_data_oe = doe_q;
   assign hreadyout = rdy_q;
   assign hrdata = rdata_q;
   assign hresp = 1'b0;
endmodule

//--- ulpi_serial_props.sv
// Concurrent checks on the ULPI wires between link and transceiver
`timescale 1ns/10ps
module ulpi_serial_props (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ULPI wires
   input wire logic dir,
   input wire logic stp,
   input wire logic [7:0] phy_data_oe,
   input wire logic [7:0] link_data_oe,
   input wire logic [7:0] data
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////
   // Wake request, and a serial cycle past the turnaround
   sequence wake_seq;
      dir && stp;
   endsequence
   sequence settled_seq;
      dir && $past(dir);
   endsequence
   ////////////////////////////////////////
   exit_dir_a: assert property (wake_seq |=> !dir)
      else $error("dir stayed high after stop");
   stp_hold_a: assert property (wake_seq |=> stp)
      else $error("stop dropped before dir fell");
   fell_oe_a: assert property ($fell(dir) |-> phy_data_oe == 8'h00)
      else $error("transceiver still drives after exit");
   dir_oe_a: assert property (settled_seq |-> phy_data_oe[7:3] == 5'h1f)
      else $error("serial outputs not driven");
   top_low_a: assert property (settled_seq |-> data[7] == 1'b0)
      else $error("bit 7 not low in serial mode");
   diff_copy_a: assert property (settled_seq |-> data[6] == data[4])
      else $error("differential receive differs from plus line");
   three_up_a: assert property (settled_seq ##0 phy_data_oe[1] |-> data[7:4] == 4'h0)
      else $error("upper bits not low in three-wire receive");
   tx_turn_a: assert property (settled_seq ##0 $past(data[0]) |-> phy_data_oe[2:0] == 3'h0)
      else $error("transceiver drives shared bits while link transmits");
   no_clash_a: assert property ((link_data_oe & phy_data_oe) == 8'h00)
      else $error("both ends drive one data line");
endmodule

//--- ulpi_serial_modes_termination_tb.sv
// Self-checking bench: link and transceiver joined over ULPI
`timescale 1ns/10ps
module ulpi_serial_modes_termination_tb import ulpi_serial_pkg::*; ;
   logic hclk = 0, hresetn = 0, clk_en = 1, hsel = 0, hwrite = 0, line_plus = 0, line_minus = 0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0, hrdata, rd, r;
   logic [3:0] int_source = 4'h0;
   logic [7:0] e;
   logic hreadyout, hresp, tx_en, tx_val, tx_zero, pu, ppd, mpd, term, clk_run, it;
   int error_cnt = 0, n_compared = 0;
   // Rows: pulldowns, speed, termination, opmode; last row is randomised
   int rows[$] = '{'h3002, 'h3000, 'h3110, 'h3310, 'h3112, 'h3210, 'h3100, 'h0012, 'h2000, 'h0};
   ulpi_if u_bus ();
   ulpi_serial_phy u_ulpi_serial_phy (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
      .ulpi(u_bus), .line_plus(line_plus), .line_minus(line_minus), .int_source(int_source),
      .serial_tx_enable(tx_en), .serial_tx_diff_value(tx_val),
      .serial_tx_single_ended_zero(tx_zero), .plus_pullup_on(pu), .plus_pulldown_on(ppd),
      .minus_pulldown_on(mpd), .fast_termination_on(term), .clock_running(clk_run));
   ulpi_serial_link u_ulpi_serial_link (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .ulpi(u_bus));
   ulpi_serial_props u_props (.hclk(hclk), .hresetn(hresetn), .dir(u_bus.dir),
      .stp(u_bus.stp), .phy_data_oe(u_bus.phy_data_oe), .link_data_oe(u_bus.link_data_oe),
      .data(u_bus.data));
   always #10 hclk = ~hclk;
   ////////////////////////////////////////
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits on hreadyout mid-cycle, so the edge that samples it is never raced
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wait_bit(int b, logic v);
      int k;
      k = 0;
      do begin
         xfer(1'b0, A_STATUS, 32'h0);
         k++;
      end while (rd[b] !== v && k < 60);
      check("status", rd[b], v);
   endtask
   task automatic reg_wr(logic [5:0] a, logic [7:0] d);
      xfer(1'b1, A_CMD, {18'h0, a, d});
      wait_bit(0, 1'b0);
   endtask
   // Resistor decode as {pull-up, plus pull-down, minus pull-down, termination}
   function automatic logic [3:0] res_model(int sp, int tm, int om, int pd);
      if (om == 1) return 4'h0;
      return {tm == 1 && pd[0] == 0, pd[0] == 1, pd[1] == 1, sp == 0 && tm == 0};
   endfunction
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      #200000;
      error_cnt++;
      summarize();
   end
   initial begin
      void'($urandom(32'h0a012170));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(negedge hclk);
      check("powerup", {pu, ppd, mpd, term}, res_model(1, 0, 0, 3));
      foreach (rows[i]) begin
         r = rows[i];
         if (i == rows.size() - 1) r = ($urandom & 32'h3310) | 32'h1;
         reg_wr(REG_OTG, {5'h0, r[13:12], 1'b0});
         reg_wr(REG_FUNC, {3'h2, r[1:0], r[4], r[9:8]});
         repeat (3) @(negedge hclk);
         check("res", {pu, ppd, mpd, term}, res_model(r[11:8], r[7:4], r[3:0], r[15:12]));
      end
      for (int m = 0; m < 2; m++) begin
         reg_wr(REG_IFC, m ? 8'h02 : 8'h09);
         wait_bit(3, 1'b1);
         check("clock", clk_run, m == 0);
         repeat (6) begin
            @(posedge hclk);
            r = $urandom;
            line_plus <= r[1];
            line_minus <= r[0];
            int_source <= r[5:2];
            xfer(1'b1, A_SERTX, {29'h0, r[8:6]});
            repeat (8) @(negedge hclk);
            it = |r[5:2];
            if (m == 0) e = {1'b0, r[1], r[0], r[1], it, r[8:6]};
            else if (r[6]) e = {4'h0, it, r[8:6]};
            else e = {4'h0, it, ~r[1] & ~r[0], r[1], 1'b0};
            check("bus", u_bus.data, e);
            check("tx", {tx_zero, tx_val, tx_en}, r[6] ? r[8:6] : 3'h0);
            // Enable low must hold every flop, even with the plus line moving
            @(posedge hclk);
            clk_en <= 1'b0;
            line_plus <= ~r[1];
            repeat (4) @(negedge hclk);
            check("freeze", u_bus.data, e);
            @(posedge hclk);
            clk_en <= 1'b1;
            line_plus <= r[1];
         end
         xfer(1'b1, A_EXIT, 32'h1);
         wait_bit(3, 1'b0);
         check("clock", clk_run, 1'b1);
      end
      xfer(1'b0, 8'h10, 32'h0);
      check("unmapped", rd, 32'h0);
      summarize();
   end
endmodule
